// >>> rtl/iics_top.sv
// interrupt summary registers and per-channel function pointer with channel bitmaps
`timescale 1ns/1ps
`include "iics_regs.svh"
module iics_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // host register port
    input wire iics_pkg::iics_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // status sources from the framer
    input wire iics_pkg::iics_irq_in_t irq_in,
    // summary and per-channel selections
    output logic [7:0] irq_source_summary_low,
    output logic [7:0] irq_source_summary_high,
    output logic [7:0] channel_function_pointer,
    output logic [31:0] tx_pattern_channel_sel,
    output logic [31:0] tx_fractional_channel_sel,
    output logic [31:0] payload_err_insert_sel,
    output logic [31:0] tx_hw_signaling_sel,
    output logic [31:0] rx_pattern_channel_sel,
    output logic [31:0] rx_fractional_channel_sel,
    output logic [31:0] rx_signaling_reinsert_sel,
    output logic [31:0] rx_signaling_all_ones_sel
);
    logic [7:0] sum_lo_r;
    logic [7:0] sum_lo_nxt;
    logic [7:0] sum_hi_r;
    logic [7:0] sum_hi_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    iics_pkg::iics_state_t st_r;
    iics_pkg::iics_state_t st_nxt;
    logic [8:0] sr_active;
    logic map_wr;
    logic [1:0] map_idx;
    logic [31:0] maps [0:7];
    logic [31:0] rd_map;

    // masked status per register
    always_comb
    begin
        for (int i = 0; i < `IICS_NUM_SR; i++)
        begin
            sr_active[i] = |(irq_in.status[i] & irq_in.mask[i]);
        end
    end

    // summary bytes follow the masked status and the extra source flag, writes to them are ignored
    always_comb
    begin
        sum_lo_nxt = sr_active[7:0];
        sum_hi_nxt = `IICS_RST_BYTE;
        sum_hi_nxt[`IICS_FLD_SR9] = sr_active[8];
        sum_hi_nxt[`IICS_FLD_EXTRA] = irq_in.extra_status_source_flag;
    end

    // bitmap write decode
    always_comb
    begin
        map_wr = req.wr && (req.addr >= `IICS_OFS_MAP_1_8) && (req.addr <= `IICS_OFS_MAP_25_32);
        map_idx = 2'(req.addr - `IICS_OFS_MAP_1_8);
    end

    // pointer register
    always_comb
    begin
        ptr_nxt = ptr_r;
        if (req.wr && req.addr == `IICS_OFS_POINTER)
            ptr_nxt = req.wdata;
    end

    // one bitmap store per function
    for (genvar f = 0; f < `IICS_NUM_FUNC; f++)
    begin : g_func
        iics_func_map u_map (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .sel(ptr_r[f]),
            .wr_en(map_wr),
            .idx(map_idx),
            .wdata(req.wdata),
            .chan_map(maps[f])
        );
    end

    // read returns the lowest selected function's map
    always_comb
    begin
        rd_map = 32'h00000000;
        for (int f = `IICS_NUM_FUNC - 1; f >= 0; f--)
        begin
            if (ptr_r[f])
                rd_map = maps[f];
        end
    end

    // read data mux; reading summaries clears nothing
    always_comb
    begin
        rdata_nxt = rdata_r;
        st_nxt = iics_pkg::IICS_IDLE;
        if (req.rd)
        begin
            st_nxt = iics_pkg::IICS_ANSWER;
            case (req.addr)
                `IICS_OFS_SUM_LOW: rdata_nxt = sum_lo_r;
                `IICS_OFS_SUM_HIGH: rdata_nxt = sum_hi_r;
                `IICS_OFS_POINTER: rdata_nxt = ptr_r;
                `IICS_OFS_MAP_1_8: rdata_nxt = rd_map[7:0];
                `IICS_OFS_MAP_9_16: rdata_nxt = rd_map[15:8];
                `IICS_OFS_MAP_17_24: rdata_nxt = rd_map[23:16];
                `IICS_OFS_MAP_25_32: rdata_nxt = rd_map[31:24];
                default: rdata_nxt = `IICS_RST_BYTE;
            endcase
        end
    end

    // register stage
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sum_lo_r <= `IICS_RST_BYTE;
            sum_hi_r <= `IICS_RST_BYTE;
            ptr_r <= `IICS_RST_BYTE;
            rdata_r <= `IICS_RST_BYTE;
            st_r <= iics_pkg::IICS_IDLE;
        end
        else
        begin
            sum_lo_r <= sum_lo_nxt;
            sum_hi_r <= sum_hi_nxt;
            ptr_r <= ptr_nxt;
            rdata_r <= rdata_nxt;
            st_r <= st_nxt;
        end
    end

    assign rdata = rdata_r;
    assign rvalid = st_r[0]; // only the answer state has bit 0 set, so the pulse comes straight from the flop
    assign irq_source_summary_low = sum_lo_r;
    assign irq_source_summary_high = sum_hi_r;
    assign channel_function_pointer = ptr_r;
    assign tx_pattern_channel_sel = maps[0];
    assign tx_fractional_channel_sel = maps[1];
    assign payload_err_insert_sel = maps[2];
    assign tx_hw_signaling_sel = maps[3];
    assign rx_pattern_channel_sel = maps[4];
    assign rx_fractional_channel_sel = maps[5];
    assign rx_signaling_reinsert_sel = maps[6];
    assign rx_signaling_all_ones_sel = maps[7];

    // a read request seen at the port
    sequence s_rd_req;
        req.rd;
    endsequence

    // the answer pulse one cycle after the request
    sequence s_rd_answer;
        ##1 rvalid;
    endsequence

    // read of the lowest bitmap byte with only the first function selected
    sequence s_map1_rd;
        req.rd && req.addr == `IICS_OFS_MAP_1_8 && ptr_r == 8'h01;
    endsequence

    // summary low follows masked status one cycle later
    a_sum_low_track: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 sum_lo_r == $past(sr_active[7:0])) else $error("summary low wrong");

    // unused summary high bits stay zero
    a_sum_high_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        sum_hi_r[7:2] == 6'h00) else $error("summary high unused bits set");

    // bit 1 of summary high tracks the extra source
    a_sum_high_extra: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 sum_hi_r[1] == $past(irq_in.extra_status_source_flag)) else $error("extra bit wrong");

    // bit 0 of summary high tracks the ninth status register
    a_sum_high_sr9: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 sum_hi_r[0] == $past(sr_active[8])) else $error("ninth status bit wrong");

    // pointer write lands next cycle
    a_ptr_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        req.wr && req.addr == `IICS_OFS_POINTER
        |=> ptr_r == $past(req.wdata)) else $error("pointer write lost");

    // pointer keeps its value when not written
    a_ptr_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !(req.wr && req.addr == `IICS_OFS_POINTER) |=> $stable(ptr_r)) else $error("pointer changed unwritten");

    // bitmap write reaches a selected function
    a_map_load: assert property (@(posedge ref_clk) disable iff (!nrst)
        req.wr && req.addr == `IICS_OFS_MAP_9_16 && ptr_r[0] && !(req.rd)
        |=> tx_pattern_channel_sel[15:8] == $past(req.wdata)) else $error("bitmap not loaded");

    // unselected function keeps its map
    a_map_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !ptr_r[7] |=> $stable(rx_signaling_all_ones_sel)) else $error("unselected map changed");

    // masked-off status never raises the summary
    a_mask_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        irq_in.mask[0] == 8'h00 |=> !sum_lo_r[0]) else $error("masked status leaked");

    // reading the summary answers next cycle with its value
    a_sum_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        req.rd && req.addr == `IICS_OFS_SUM_LOW
        |=> rvalid && rdata == $past(sum_lo_r)) else $error("summary read wrong");

    // every read is answered by a pulse one cycle later
    a_read_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_rd_req |-> s_rd_answer) else $error("read not answered");

    // no answer pulse without a read
    a_no_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
        !req.rd |=> !rvalid) else $error("answer without read");

    // a single selected function reads back its own lowest map byte
    a_map_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_map1_rd |=> rvalid && rdata == $past(tx_pattern_channel_sel[7:0])) else $error("map read wrong");

    // offsets above the last bitmap read as zero
    a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        req.rd && req.addr > `IICS_OFS_MAP_25_32 |=> rdata == `IICS_RST_BYTE) else $error("unmapped read not zero");
endmodule : iics_top

// >>> rtl/iics_regs.svh
// register offsets, field positions and reset values of the interrupt summary and channel select block
// Overview of operation
// - summary low bit n flags status register n+1 producing an interrupt
// - summary high bit 0 is status register 9, bit 1 extra source, rest zero
// - pointer register holds eight per-channel function select bits
// - bitmap write loads every function whose pointer bit is set
// - four bitmaps cover channels 1 to 32, lowest channel in bit 0
// - status bit reaches a summary bit only when its mask bit is one
`ifndef IICS_REGS_SVH
`define IICS_REGS_SVH

`define IICS_OFS_SUM_LOW 8'h14
`define IICS_OFS_SUM_HIGH 8'h15
`define IICS_OFS_POINTER 8'h28
`define IICS_OFS_MAP_1_8 8'h29
`define IICS_OFS_MAP_9_16 8'h2A
`define IICS_OFS_MAP_17_24 8'h2B
`define IICS_OFS_MAP_25_32 8'h2C
`define IICS_RST_BYTE 8'h00
`define IICS_NUM_SR 9
`define IICS_NUM_FUNC 8
`define IICS_NUM_MAP 4
`define IICS_FLD_SR9 0
`define IICS_FLD_EXTRA 1

`endif

// >>> rtl/iics_pkg.sv
// types shared by the interrupt summary and channel select block
package iics_pkg;
    // one host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iics_req_t;

    // status and mask bytes of the nine status registers
    typedef struct packed {
        logic [8:0][7:0] status;
        logic [8:0][7:0] mask;
        logic extra_status_source_flag;
    } iics_irq_in_t;

    // read path states
    typedef enum logic [1:0] {
        IICS_IDLE = 2'b00,
        IICS_ANSWER = 2'b01
    } iics_state_t;
endpackage : iics_pkg

// >>> rtl/iics_func_map.sv
// channel bitmap store for one per-channel function
`timescale 1ns/1ps
`include "iics_regs.svh"
module iics_func_map (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // write port
    input wire logic sel,
    input wire logic wr_en,
    input wire logic [1:0] idx,
    input wire logic [7:0] wdata,
    // stored 32-channel map
    output logic [31:0] chan_map
);
    logic [31:0] map_r;
    logic [31:0] map_nxt;

    // byte of the selected bitmap is loaded when this function is pointed at
    always_comb
    begin
        map_nxt = map_r;
        if (wr_en && sel)
        begin
            map_nxt[idx*8 +: 8] = wdata;
        end
    end

    // register the map
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            map_r <= {4{`IICS_RST_BYTE}};
        else
            map_r <= map_nxt;
    end

    assign chan_map = map_r;
endmodule : iics_func_map

// >>> testbench/iics_host.sv
// host processor model on the parallel register port
`timescale 1ns/1ps
module iics_host (
    // clock
    input wire logic ref_clk,
    // register port
    output iics_pkg::iics_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    // port idle from time zero
    initial req = '0;
    // write: strobe launched on one edge, taken and dropped on the next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk) req <= '0;
    endtask : wr
    // read: caller keeps at most one function selected before map reads
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk) req <= '0;
        #1;
        ok = rvalid;
        d = rdata;
    endtask : rd
endmodule : iics_host

// >>> testbench/interrupt_info_and_channel_select_tb.sv
// self-checking bench of the summary and channel select block
`timescale 1ns/1ps
module interrupt_info_and_channel_select_tb;
    logic ref_clk;
    logic nrst;
    iics_pkg::iics_req_t req;
    iics_pkg::iics_irq_in_t irq_in;
    logic [7:0] rdata, lo, hi, ptr, d, elo, ehi, eptr;
    logic rvalid, ok;
    logic [159:0] rnd;
    logic [31:0] sel [8];
    logic [31:0] em [8];
    int errors = 0;
    int cmp_count = 0;
    iics_host host_u (.ref_clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    iics_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .irq_in(irq_in), .irq_source_summary_low(lo), .irq_source_summary_high(hi),
        .channel_function_pointer(ptr), .tx_pattern_channel_sel(sel[0]), .tx_fractional_channel_sel(sel[1]),
        .payload_err_insert_sel(sel[2]), .tx_hw_signaling_sel(sel[3]), .rx_pattern_channel_sel(sel[4]),
        .rx_fractional_channel_sel(sel[5]), .rx_signaling_reinsert_sel(sel[6]),
        .rx_signaling_all_ones_sel(sel[7]));
    // 50 ns clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // counts, verdict and end of run
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    // read one register and compare
    task automatic rck(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, d, ok);
        chk({31'h0, ok}, 32'h1);
        chk({24'h0, d}, {24'h0, e});
    endtask : rck
    // all maps and pointer against the model
    task automatic mck();
        for (int f = 0; f < 8; f++) chk(sel[f], em[f]);
        chk({24'h0, ptr}, {24'h0, eptr});
    endtask : mck
    // hang guard
    initial
    begin
        #(50 * 20000);
        errors++;
        results();
    end
    // test sequence
    initial
    begin
        void'($urandom(32'h42614e03));
        irq_in = '0;
        nrst = 1'b0;
        eptr = 8'h00;
        for (int f = 0; f < 8; f++) em[f] = '0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        #1;
        mck();
        chk({16'h0, hi, lo}, 32'h0);
        for (int a = 8'h28; a <= 8'h2C; a++) rck(8'(a), 8'h00);
        $display("end reset");
        for (int i = 0; i < 30; i++)
        begin
            rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
            @(posedge ref_clk) irq_in <= rnd[144:0];
            repeat (2) @(posedge ref_clk);
            #1;
            for (int r = 0; r < 8; r++) elo[r] = |(irq_in.status[r] & irq_in.mask[r]);
            ehi = {6'h0, irq_in.extra_status_source_flag, |(irq_in.status[8] & irq_in.mask[8])};
            chk({24'h0, lo}, {24'h0, elo});
            chk({24'h0, hi}, {24'h0, ehi});
        end
        host_u.wr(8'h14, 8'hFF);
        host_u.wr(8'h15, 8'hFF);
        rck(8'h14, elo);
        rck(8'h15, ehi);
        chk({16'h0, hi, lo}, {16'h0, ehi, elo});
        $display("end summary");
        for (int i = 0; i < 30; i++)
        begin
            d = 8'($urandom);
            if (i % 3 == 0)
            begin
                host_u.wr(8'h28, d);
                eptr = d;
            end
            else
            begin
                automatic int x = $urandom_range(3, 0);
                host_u.wr(8'h29 + 8'(x), d);
                for (int f = 0; f < 8; f++) if (eptr[f]) em[f][x * 8 +: 8] = d;
            end
            #1;
            mck();
        end
        host_u.wr(8'h30, 8'hFF);
        #1;
        mck();
        for (int f = 0; f < 8; f++)
        begin
            eptr = 8'h01 << f;
            host_u.wr(8'h28, eptr);
            rck(8'h28, eptr);
            for (int x = 0; x < 4; x++) rck(8'h29 + 8'(x), em[f][x * 8 +: 8]);
        end
        rck(8'h30, 8'h00);
        $display("end channel maps");
        results();
    end
endmodule : interrupt_info_and_channel_select_tb
